/* pkg/dtc_pkg.sv */
// dtc_pkg: addresses, field positions and reset values for the dual
// timer/counter block; assumes an 8-bit special register port.
package dtc_pkg;
  // special register addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h88;
  localparam logic [7:0] ADDR_MODE   = 8'h89;
  localparam logic [7:0] ADDR_A_LOW  = 8'h8A;
  localparam logic [7:0] ADDR_B_LOW  = 8'h8B;
  localparam logic [7:0] ADDR_A_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_B_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_PRESC  = 8'h8E;
  localparam logic [7:0] ADDR_IEN    = 8'hA8;
  localparam logic [7:0] ADDR_IPRI   = 8'hB8;
  // control register bits
  localparam int B_FLAG_B = 7;
  localparam int B_RUN_B  = 6;
  localparam int B_FLAG_A = 5;
  localparam int B_RUN_A  = 4;
  // mode register fields
  localparam int B_SRC_B  = 6;
  localparam int B_MODE_B = 4;
  localparam int B_SRC_A  = 2;
  localparam int B_MODE_A = 0;
  // prescale bits
  localparam int B_PRE_A  = 0;
  localparam int B_PRE_B  = 1;
  localparam int B_PRE_C  = 2;
  // interrupt enable / priority bits
  localparam int B_GIE    = 7;
  localparam int B_IEN_B  = 3;
  localparam int B_IEN_A  = 1;
  // writable masks: reserved bits read zero
  localparam logic [7:0] MASK_CTRL  = 8'hF0;
  localparam logic [7:0] MASK_MODE  = 8'h77;
  localparam logic [7:0] MASK_PRESC = 8'h07;
  localparam logic [7:0] MASK_IEN   = 8'hFB;
  localparam logic [7:0] MASK_IPRI  = 8'h7B;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  // prescaler
  localparam int         PRE_DIV    = 12;
  localparam logic [3:0] PRE_LAST   = 4'(PRE_DIV - 1);
  localparam logic [4:0] LOW5_MAX   = 5'h1F;
  localparam logic [7:0] BYTE_MAX   = 8'hFF;
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } dtc_mode_t;
endpackage : dtc_pkg

/* verilog/dtc_top.sv */
// dtc_top: two up-counting timer/counters with mode, prescale and
// interrupt enable/priority registers on the special register port.
// Assumes one MCLK domain; count pins are synchronous to MCLK.
// Function
// - timer B source bit: 0 counts system clock, 1 counts its pin
// - timer A source bit: 1 counts its pin, 0 counts system clock
// - timer B mode 00: 13-bit count, low byte top bits idle
// - timer B mode 01: full 16-bit count
// - timer B mode 10: 8-bit low byte reloads from high byte
// - timer B mode 11: stops and holds value
// - timer A mode 00: 13-bit count, low byte top bits idle
// - timer A mode 01: full 16-bit count
// - timer A mode 10: 8-bit low byte reloads from high byte
// - timer A mode 11: low byte independent 8-bit, A controls
// - split mode: A high byte timer only, uses B run and flag
// - mode bits 2..0 timer A, 6..4 timer B, 7 and 3 reserved
// - timers count only while their run bit is 1
// - timer B prescale: 0 is clock/12, 1 is undivided clock
// - timer A prescale: 0 is clock/12, 1 is undivided clock
// - enable bit 3 gates timer B interrupt
// - enable bit 1 gates timer A interrupt
// - priority bit 3 sets timer B interrupt high
// - priority bit 1 sets timer A interrupt high
// - overflow sets flag; vectoring to handler clears it
// - setting run bit keeps count value
// - counter mode: each pin falling edge adds one
// - split mode stops timer B own counter
`timescale 1ns/1ps
module dtc_top (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // special register port
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WE,
  input  wire logic       SFR_RE,
  output logic      [7:0] SFR_RDATA,
  // count pins
  input  wire logic       CNT_A_PIN,
  input  wire logic       CNT_B_PIN,
  // interrupt side
  input  wire logic       VEC_A_ACK,
  input  wire logic       VEC_B_ACK,
  output logic            IRQ_A,
  output logic            IRQ_B,
  output logic            IRQ_A_HIGH,
  output logic            IRQ_B_HIGH
);
  logic [7:0] ctrl_r, ctrl_nxt, mode_r, mode_nxt, pre_r, pre_nxt;
  logic [7:0] ien_r, ien_nxt, ipri_r, ipri_nxt;
  logic [7:0] al_r, al_nxt, ah_r, ah_nxt, bl_r, bl_nxt, bh_r, bh_nxt;
  logic [3:0] div_r, div_nxt;
  logic [1:0] pa_r, pa_nxt, pb_r, pb_nxt;
  logic       pa_d_r, pa_d_nxt, pb_d_r, pb_d_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic       irqa_r, irqa_nxt, irqb_r, irqb_nxt;
  logic       pha_r, pha_nxt, phb_r, phb_nxt;
  logic       tick12, edge_a, edge_b, tick_a, tick_b, tick_ah;
  logic       run_a, run_b, split;
  logic       ovf_a, ovf_b;
  dtc_pkg::dtc_mode_t ma, mb;

  // clock tick for timer use: undivided or divide-by-12
  function automatic logic sel_tick(input logic pre, input logic t12);
    sel_tick = pre ? 1'b1 : t12;
  endfunction : sel_tick

  // one 16-bit step in modes 0..3; returns {ovf, high, low}
  function automatic logic [16:0] step(input dtc_pkg::dtc_mode_t m,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    unique case (m)
      dtc_pkg::MODE_13BIT: begin
        if (lo[4:0] == dtc_pkg::LOW5_MAX) begin
          r[4:0] = 5'h00;
          r[16:8] = {1'b0, hi} + 9'h001;
        end else begin
          r[4:0] = lo[4:0] + 5'h01;
        end
      end
      dtc_pkg::MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
      dtc_pkg::MODE_RELOAD: begin
        if (lo == dtc_pkg::BYTE_MAX) r = {1'b1, hi, hi};
        else r[7:0] = lo + 8'h01;
      end
      dtc_pkg::MODE_SPLIT: begin
        r[8:0] = {1'b0, lo} + 9'h001;
        r[16] = r[8];
        r[15:8] = hi;
      end
    endcase
    step = r;
  endfunction : step

  assign ma    = dtc_pkg::dtc_mode_t'(mode_r[dtc_pkg::B_MODE_A +: 2]);
  assign mb    = dtc_pkg::dtc_mode_t'(mode_r[dtc_pkg::B_MODE_B +: 2]);
  assign split = (ma == dtc_pkg::MODE_SPLIT);
  assign run_a = ctrl_r[dtc_pkg::B_RUN_A];
  assign run_b = ctrl_r[dtc_pkg::B_RUN_B];
  assign tick12 = (div_r == dtc_pkg::PRE_LAST);
  assign edge_a = pa_d_r & ~pa_r[1]; // falling edge
  assign edge_b = pb_d_r & ~pb_r[1];
  // source select per timer
  assign tick_a = mode_r[dtc_pkg::B_SRC_A] ? edge_a
                : sel_tick(pre_r[dtc_pkg::B_PRE_A], tick12);
  assign tick_b = mode_r[dtc_pkg::B_SRC_B] ? edge_b
                : sel_tick(pre_r[dtc_pkg::B_PRE_B], tick12);
  // split high byte is a timer only, never the pin
  assign tick_ah = sel_tick(pre_r[dtc_pkg::B_PRE_A], tick12);

  // prescaler and pin synchronisers
  always_comb begin
    div_nxt  = tick12 ? 4'h0 : div_r + 4'h1;
    pa_nxt   = {pa_r[0], CNT_A_PIN};
    pb_nxt   = {pb_r[0], CNT_B_PIN};
    pa_d_nxt = pa_r[1];
    pb_d_nxt = pb_r[1];
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_r  <= 4'h0;
      pa_r   <= 2'b11;
      pb_r   <= 2'b11;
      pa_d_r <= 1'b1;
      pb_d_r <= 1'b1;
    end else begin
      div_r  <= div_nxt;
      pa_r   <= pa_nxt;
      pb_r   <= pb_nxt;
      pa_d_r <= pa_d_nxt;
      pb_d_r <= pb_d_nxt;
    end
  end

  // counters, flags and register writes; hardware set beats clear
  always_comb begin
    logic [16:0] sa, sb;
    logic [8:0]  sh;
    sa = step(ma, al_r, ah_r);
    sb = step(mb, bl_r, bh_r);
    sh = {1'b0, ah_r} + 9'h001;
    ctrl_nxt = ctrl_r;
    mode_nxt = mode_r;
    pre_nxt  = pre_r;
    ien_nxt  = ien_r;
    ipri_nxt = ipri_r;
    al_nxt = al_r;
    ah_nxt = ah_r;
    bl_nxt = bl_r;
    bh_nxt = bh_r;
    ovf_a = 1'b0;
    ovf_b = 1'b0;
    if (SFR_WE) begin
      unique case (SFR_ADDR)
        dtc_pkg::ADDR_CTRL:   ctrl_nxt = SFR_WDATA & dtc_pkg::MASK_CTRL;
        dtc_pkg::ADDR_MODE:   mode_nxt = SFR_WDATA
                                       & dtc_pkg::MASK_MODE;
        dtc_pkg::ADDR_PRESC:  pre_nxt  = SFR_WDATA & dtc_pkg::MASK_PRESC;
        dtc_pkg::ADDR_IEN:    ien_nxt  = SFR_WDATA & dtc_pkg::MASK_IEN;
        dtc_pkg::ADDR_IPRI:   ipri_nxt = SFR_WDATA & dtc_pkg::MASK_IPRI;
        dtc_pkg::ADDR_A_LOW:  al_nxt   = SFR_WDATA;
        dtc_pkg::ADDR_A_HIGH: ah_nxt   = SFR_WDATA;
        dtc_pkg::ADDR_B_LOW:  bl_nxt   = SFR_WDATA;
        dtc_pkg::ADDR_B_HIGH: bh_nxt   = SFR_WDATA;
        default: ;
      endcase
    end
    // timer A (low byte alone in split mode); run kept, count kept
    if (run_a && tick_a) begin
      al_nxt = sa[7:0];
      if (!split) ah_nxt = sa[15:8];
      ovf_a = sa[16];
    end
    if (split) begin
      // high byte timer driven by B run bit, raises B flag
      if (run_b && tick_ah) begin
        ah_nxt = sh[7:0];
        ovf_b = sh[8];
      end
    end else if (run_b && tick_b && mb != dtc_pkg::MODE_SPLIT) begin
      // mode 11 holds; split stops B own count
      bl_nxt = sb[7:0];
      bh_nxt = sb[15:8];
      ovf_b = sb[16];
    end
    if (VEC_A_ACK) ctrl_nxt[dtc_pkg::B_FLAG_A] = 1'b0;
    if (VEC_B_ACK) ctrl_nxt[dtc_pkg::B_FLAG_B] = 1'b0;
    if (ovf_a) ctrl_nxt[dtc_pkg::B_FLAG_A] = 1'b1;
    if (ovf_b) ctrl_nxt[dtc_pkg::B_FLAG_B] = 1'b1;
  end

  // read data and interrupt outputs
  always_comb begin
    rd_nxt = rd_r;
    if (SFR_RE) begin
      unique case (SFR_ADDR)
        dtc_pkg::ADDR_CTRL:   rd_nxt = ctrl_r;
        dtc_pkg::ADDR_MODE:   rd_nxt = mode_r;
        dtc_pkg::ADDR_PRESC:  rd_nxt = pre_r;
        dtc_pkg::ADDR_IEN:    rd_nxt = ien_r;
        dtc_pkg::ADDR_IPRI:   rd_nxt = ipri_r;
        dtc_pkg::ADDR_A_LOW:  rd_nxt = al_r;
        dtc_pkg::ADDR_A_HIGH: rd_nxt = ah_r;
        dtc_pkg::ADDR_B_LOW:  rd_nxt = bl_r;
        dtc_pkg::ADDR_B_HIGH: rd_nxt = bh_r;
        default:              rd_nxt = dtc_pkg::RST_BYTE;
      endcase
    end
    irqa_nxt = ctrl_nxt[dtc_pkg::B_FLAG_A] & ien_nxt[dtc_pkg::B_IEN_A]
             & ien_nxt[dtc_pkg::B_GIE];
    irqb_nxt = ctrl_nxt[dtc_pkg::B_FLAG_B] & ien_nxt[dtc_pkg::B_IEN_B]
             & ien_nxt[dtc_pkg::B_GIE];
    pha_nxt = ipri_nxt[dtc_pkg::B_IEN_A];
    phb_nxt = ipri_nxt[dtc_pkg::B_IEN_B];
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= dtc_pkg::RST_BYTE;
      mode_r <= dtc_pkg::RST_BYTE;
      pre_r  <= dtc_pkg::RST_BYTE;
      ien_r  <= dtc_pkg::RST_BYTE;
      ipri_r <= dtc_pkg::RST_BYTE;
      al_r   <= dtc_pkg::RST_BYTE;
      ah_r   <= dtc_pkg::RST_BYTE;
      bl_r   <= dtc_pkg::RST_BYTE;
      bh_r   <= dtc_pkg::RST_BYTE;
      rd_r   <= dtc_pkg::RST_BYTE;
      irqa_r <= 1'b0;
      irqb_r <= 1'b0;
      pha_r  <= 1'b0;
      phb_r  <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_r <= mode_nxt;
      pre_r  <= pre_nxt;
      ien_r  <= ien_nxt;
      ipri_r <= ipri_nxt;
      al_r   <= al_nxt;
      ah_r   <= ah_nxt;
      bl_r   <= bl_nxt;
      bh_r   <= bh_nxt;
      rd_r   <= rd_nxt;
      irqa_r <= irqa_nxt;
      irqb_r <= irqb_nxt;
      pha_r  <= pha_nxt;
      phb_r  <= phb_nxt;
    end
  end

  assign SFR_RDATA  = rd_r;
  assign IRQ_A      = irqa_r;
  assign IRQ_B      = irqb_r;
  assign IRQ_A_HIGH = pha_r;
  assign IRQ_B_HIGH = phb_r;

  // checks
  a_hold_mode3: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    (mb == dtc_pkg::MODE_SPLIT && !split && !SFR_WE) |=> $stable(bl_r))
    else $error("timer B moved in stop mode");
  a_stop_run_a: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    (!run_a && !SFR_WE) |=> $stable(al_r))
    else $error("timer A counted while stopped");
  a_pin_count: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    (mode_r[dtc_pkg::B_SRC_A] && run_a && ma == dtc_pkg::MODE_16BIT
     && edge_a && !SFR_WE) |=> ({ah_r, al_r} == $past({ah_r, al_r}) + 16'h1))
    else $error("pin edge not counted");
  a_reload_a: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    (ma == dtc_pkg::MODE_RELOAD && run_a && tick_a && al_r == 8'hFF
     && !SFR_WE) |=> (al_r == ah_r && ctrl_r[dtc_pkg::B_FLAG_A]))
    else $error("reload or flag missing");
  a_split_b: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    (split && !SFR_WE) |=> $stable(bl_r) && $stable(bh_r))
    else $error("timer B counted in split");
  a_irq_gate: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    IRQ_A |-> $past(ien_nxt[dtc_pkg::B_GIE] & ien_nxt[dtc_pkg::B_IEN_A]))
    else $error("irq A without enables");
  // tick every 12th cycle: one tick, eleven quiet cycles, then a tick
  a_div_twelve: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
    else $error("prescale period wrong");
  a_flag_a_set: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    ovf_a |=> ctrl_r[dtc_pkg::B_FLAG_A])
    else $error("flag A not set");
  a_13bit_b: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    (mb == dtc_pkg::MODE_13BIT && !split && !SFR_WE) |=> $stable(bl_r[7:5]))
    else $error("13-bit top bits moved");
  c_ovf_b: cover property (@(posedge MCLK) ovf_b);
  c_split: cover property (@(posedge MCLK) split && run_b && tick_ah);
  c_irq_b: cover property (@(posedge MCLK) IRQ_B && IRQ_B_HIGH);
endmodule : dtc_top

/* verification/dtc_pin_model.sv */
// dtc_pin_model: far side of the count pins, idle high, one falling
// edge per request. Assumes go_a/go_b last one MCLK cycle each.
`timescale 1ns/1ps
module dtc_pin_model (
  // clock
  input  wire logic clk,
  // pulse requests and pulse length
  input  wire logic go_a,
  input  wire logic go_b,
  input  wire logic slow,
  // count pins
  output logic      pin_a,
  output logic      pin_b
);
  int cnt_a = 0;
  int cnt_b = 0;
  // low phase counters, long when slow
  always @(posedge clk) begin
    if (go_a) cnt_a <= slow ? 8 : 2;
    else if (cnt_a > 0) cnt_a <= cnt_a - 1;
    if (go_b) cnt_b <= slow ? 8 : 2;
    else if (cnt_b > 0) cnt_b <= cnt_b - 1;
  end
  // pins low only while a pulse runs
  assign pin_a = !(cnt_a > 0);
  assign pin_b = !(cnt_b > 0);
endmodule : dtc_pin_model

/* verification/dtc_top_tb.sv */
// dtc_top_tb: register-level tests of the dual timer block.
// Assumes dtc_top, dtc_pkg and dtc_pin_model are compiled first.
`timescale 1ns/1ps
module dtc_top_tb;
  localparam logic [7:0] CT = dtc_pkg::ADDR_CTRL;
  localparam logic [7:0] MO = dtc_pkg::ADDR_MODE;
  localparam logic [7:0] AL = dtc_pkg::ADDR_A_LOW;
  localparam logic [7:0] AH = dtc_pkg::ADDR_A_HIGH;
  localparam logic [7:0] BL = dtc_pkg::ADDR_B_LOW;
  localparam logic [7:0] BH = dtc_pkg::ADDR_B_HIGH;
  localparam logic [7:0] PS = dtc_pkg::ADDR_PRESC;
  localparam logic [7:0] EN = dtc_pkg::ADDR_IEN;
  localparam logic [7:0] PR = dtc_pkg::ADDR_IPRI;
  typedef struct {
    logic b; logic [1:0] m; logic [7:0] l, h, el, eh; logic f;
  } dtc_case_t;
  logic       MCLK = 1'h0, RST_N = 1'h0, we = 1'h0, re = 1'h0;
  logic       go_a = 1'h0, go_b = 1'h0, slow = 1'h0;
  logic       ack_a = 1'h0, ack_b = 1'h0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd, v, lo, hi, rb, fb;
  logic       pa, pb, irq_a, irq_b, hi_a, hi_b, b, p;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         n;
  logic [7:0] ra [6] = '{CT, MO, PS, EN, PR, 8'h90};
  logic [7:0] rm [6] = '{8'hF0, 8'h77, 8'h07, 8'hFB, 8'h7B, 8'h00};
  dtc_case_t  tc [9] = '{
    '{1'h0, 2'h0, 8'h1F, 8'hFF, 8'h00, 8'h00, 1'h1},
    '{1'h0, 2'h1, 8'hFF, 8'h00, 8'h00, 8'h01, 1'h0},
    '{1'h0, 2'h1, 8'hFF, 8'hFF, 8'h00, 8'h00, 1'h1},
    '{1'h0, 2'h2, 8'hFF, 8'h5A, 8'h5A, 8'h5A, 1'h1},
    '{1'h0, 2'h3, 8'hFE, 8'h33, 8'hFF, 8'h33, 1'h0},
    '{1'h1, 2'h0, 8'h1F, 8'hFF, 8'h00, 8'h00, 1'h1},
    '{1'h1, 2'h1, 8'hFF, 8'h00, 8'h00, 8'h01, 1'h0},
    '{1'h1, 2'h2, 8'hFF, 8'hA5, 8'hA5, 8'hA5, 1'h1},
    '{1'h1, 2'h3, 8'h12, 8'h34, 8'h12, 8'h34, 1'h0}};
  // free running 25 MHz clock
  always #20 MCLK = ~MCLK;
  dtc_top uut (.MCLK(MCLK), .RST_N(RST_N), .SFR_ADDR(addr),
    .SFR_WDATA(wd), .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rd),
    .CNT_A_PIN(pa), .CNT_B_PIN(pb), .VEC_A_ACK(ack_a),
    .VEC_B_ACK(ack_b), .IRQ_A(irq_a), .IRQ_B(irq_b),
    .IRQ_A_HIGH(hi_a), .IRQ_B_HIGH(hi_b));
  dtc_pin_model pm (.clk(MCLK), .go_a(go_a), .go_b(go_b), .slow(slow),
    .pin_a(pa), .pin_b(pb));
  // bus tasks, entered and left 1 ns after a rising edge
  task step(input int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask : step
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    we = 1'h1;
    step(1);
    we = 1'h0;
    step(1);
  endtask : wr
  task rdr(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    re = 1'h1;
    step(1);
    d = rd;
    re = 1'h0;
    step(1);
  endtask : rdr
  task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rdr(a, d);
    cmp(nm, e, d);
  endtask : chk
  task pulse(input logic sel);
    if (sel) go_b = 1'h1;
    else go_a = 1'h1;
    step(1);
    go_a = 1'h0;
    go_b = 1'h0;
    step(12);
  endtask : pulse
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    step(8);
    RST_N = 1'h1;
    step(1);
    // reset values and reserved bits of the setup registers
    foreach (ra[i]) begin
      chk("reset", ra[i], 8'h00);
      wr(ra[i], 8'hFF);
      chk("mask", ra[i], rm[i]);
      wr(ra[i], 8'h00);
    end
    // one pin pulse per mode and timer, then flag and byte values
    foreach (tc[i]) begin
      b = tc[i].b;
      lo = b ? BL : AL;
      hi = b ? BH : AH;
      rb = b ? 8'h40 : 8'h10;
      fb = b ? 8'h80 : 8'h20;
      wr(MO, b ? {2'h1, tc[i].m, 4'h0} : {6'h1, tc[i].m});
      wr(lo, tc[i].l);
      wr(hi, tc[i].h);
      wr(CT, rb);
      pulse(b);
      chk("flag", CT, tc[i].f ? (rb | fb) : rb);
      wr(CT, 8'h00);
      chk("low", lo, tc[i].el);
      chk("high", hi, tc[i].eh);
    end
    // run bit gates counting and keeps the count across stops
    wr(MO, 8'h05);
    wr(AL, 8'h10);
    wr(AH, 8'h00);
    slow = 1'h1;
    pulse(0);
    chk("no run", AL, 8'h10);
    wr(CT, 8'h10);
    pulse(0);
    pulse(0);
    wr(CT, 8'h00);
    wr(CT, 8'h10);
    pulse(0);
    wr(CT, 8'h00);
    slow = 1'h0;
    chk("resume", AL, 8'h13);
    // run window spans n + 2 edges: n + 2 steps undivided, 10 at /12
    for (int k = 0; k < 4; k++) begin
      b = k[0];
      p = k[1];
      n = p ? 20 : 118;
      lo = b ? BL : AL;
      wr(PS, b ? {6'h0, p, 1'h0} : {7'h0, p});
      wr(MO, 8'h11);
      wr(lo, 8'h00);
      wr(b ? BH : AH, 8'h00);
      wr(CT, b ? 8'h40 : 8'h10);
      step(n);
      wr(CT, 8'h00);
      rdr(lo, v);
      cmp("timed count", p ? 8'(n + 2) : 8'h0A, v);
    end
    // split: timer A high byte runs on B run bit and raises B flag
    wr(MO, 8'h03);
    wr(PS, 8'h01);
    wr(AH, 8'hF0);
    wr(BL, 8'h77);
    wr(CT, 8'h40);
    v = 8'h00;
    for (int j = 0; j < 40 && v[7] !== 1'h1; j++) rdr(CT, v);
    cmp("split flag", 8'hC0, v);
    if (v[7] !== 1'h1) give_verdict();
    wr(CT, 8'h80);
    chk("b frozen", BL, 8'h77);
    // interrupt gating, priority and clear on vectoring
    wr(EN, 8'h08);
    cmp("irq b", 8'h00, {7'h0, irq_b});
    wr(EN, 8'h88);
    cmp("irq b", 8'h01, {7'h0, irq_b});
    wr(PR, 8'h08);
    cmp("pri", 8'h01, {6'h0, hi_a, hi_b});
    wr(PR, 8'h02);
    cmp("pri", 8'h02, {6'h0, hi_a, hi_b});
    ack_b = 1'h1;
    step(1);
    ack_b = 1'h0;
    step(2);
    cmp("ack b", 8'h00, {7'h0, irq_b});
    chk("ack b flag", CT, 8'h00);
    wr(CT, 8'h20);
    wr(EN, 8'h80);
    cmp("irq a", 8'h00, {7'h0, irq_a});
    wr(EN, 8'h82);
    cmp("irq a", 8'h01, {7'h0, irq_a});
    ack_a = 1'h1;
    step(1);
    ack_a = 1'h0;
    step(2);
    cmp("ack a", 8'h00, {7'h0, irq_a});
    // mid-run reset drops a pending request and clears the registers
    wr(CT, 8'h20);
    cmp("irq a set", 8'h01, {7'h0, irq_a});
    RST_N = 1'h0;
    step(2);
    RST_N = 1'h1;
    step(1);
    cmp("reset irq", 8'h00, {7'h0, irq_a});
    chk("reset flag", CT, 8'h00);
    chk("reset enable", EN, 8'h00);
    give_verdict();
  end
endmodule : dtc_top_tb
